// >>> include/cix_pkg.sv
// package with constants, encodings and carriers for the instruction execute subset
// ****************************************************************************
// Operation
// RULE_01 - set tested bit discards next instruction, two cycles
// RULE_02 - clear working register loads zero, sets zero
// RULE_03 - call pushes current address plus one
// RULE_04 - call loads eight-bit operand into low address
// RULE_05 - call takes page from status, address bit eight zero
// RULE_06 - call completes in two instruction cycles
// RULE_07 - watchdog clear zeroes the watchdog counter
// RULE_08 - watchdog clear clears prescaler when watchdog-assigned
// RULE_09 - watchdog clear sets timeout and powerdown flags
// RULE_10 - clear file register writes zero, sets zero
// RULE_11 - complement inverts, steers result, updates zero only
// RULE_12 - decrement subtracts one, steers result, zero only
// RULE_13 - destination bit zero working, one file
// RULE_14 - zero flag set exactly when result zero
// RULE_15 - skip and call leave status flags alone
// ****************************************************************************
package cix_pkg;

	// ************************************************************************
	// widths
	// ************************************************************************
	localparam int INSTR_W = 12; // instruction word width
	localparam int DATA_W = 8; // data path width
	localparam int PC_W = 11; // program counter width
	localparam int FADDR_W = 5; // file register address width
	localparam int FILE_DEPTH = 32; // number of file registers

	// ************************************************************************
	// status register fields and reset value
	// ************************************************************************
	localparam int ST_Z_BIT = 2; // zero flag
	localparam int ST_PD_BIT = 3; // powerdown flag, active low
	localparam int ST_TO_BIT = 4; // timeout flag, active low
	localparam int ST_PAGE_LO = 5; // page select low bit
	localparam int ST_PAGE_HI = 6; // page select high bit
	localparam logic [7:0] STATUS_RESET = 8'h18; // timeout and powerdown flags high, zero flag low after reset
	localparam logic [10:0] PC_RESET = 11'h000; // first fetch address
	localparam logic [7:0] WDT_RESET = 8'h00; // watchdog counter start

	// ************************************************************************
	// instruction encodings, mask and match
	// ************************************************************************
	localparam logic [11:0] BTSS_MASK = 12'hf00; // opcode fixed, bit and file fields free
	localparam logic [11:0] BTSS_MATCH = 12'h700;
	localparam logic [11:0] CLEAR_WORKING_REG_MASK = 12'hfff;
	localparam logic [11:0] CLEAR_WORKING_REG_MATCH = 12'h040;
	localparam logic [11:0] CALL_MASK = 12'hf00;
	localparam logic [11:0] CALL_MATCH = 12'h900;
	localparam logic [11:0] CLRWD_MASK = 12'hfff;
	localparam logic [11:0] CLRWD_MATCH = 12'h004;
	localparam logic [11:0] CLEAR_FILE_REG_MASK = 12'hfe0;
	localparam logic [11:0] CLEAR_FILE_REG_MATCH = 12'h060;
	localparam logic [11:0] COMPLEMENT_FILE_REG_MASK = 12'hfc0;
	localparam logic [11:0] COMPLEMENT_FILE_REG_MATCH = 12'h240;
	localparam logic [11:0] DECREMENT_FILE_REG_MASK = 12'hfc0;
	localparam logic [11:0] DECREMENT_FILE_REG_MATCH = 12'h0c0;
	localparam int DEST_BIT = 5; // destination select bit
	localparam int BITSEL_LO = 5; // tested bit number field
	localparam int BITSEL_HI = 7;

	// ************************************************************************
	// types
	// ************************************************************************
	typedef enum logic [2:0]
	{
		OP_NOP,
		OP_BTSS,
		OP_CLEAR_WORKING_REG,
		OP_CALL,
		OP_CLRWD,
		OP_CLEAR_FILE_REG,
		OP_COMPLEMENT_FILE_REG,
		OP_DECREMENT_FILE_REG
	} cix_op_e;

	typedef struct packed
	{
		logic valid; // one-cycle push strobe
		logic [10:0] addr; // return address
	} cix_push_s;

	typedef struct packed
	{
		logic wdt_clear; // watchdog counter cleared
		logic presc_clear; // prescaler cleared
	} cix_wdt_s;

endpackage

// >>> verilog/cix_file_mem.sv
// file register memory with registered read data
`timescale 1ns/1ps
module cix_file_mem
#(
	parameter int WIDTH = cix_pkg::DATA_W,
	parameter int DEPTH = cix_pkg::FILE_DEPTH,
	parameter int AW = cix_pkg::FADDR_W
)
(
	input wire logic sys_clk_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [WIDTH-1:0] rd_data_out,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [WIDTH-1:0] wr_data_in
);

	logic [WIDTH-1:0] mem_reg [DEPTH]; // storage array, no reset

	// write port
	always_ff @(posedge sys_clk_in)
	begin
		if (wr_en_in)
			mem_reg[wr_addr_in] <= wr_data_in;
	end

	// read port, one cycle latency
	always_ff @(posedge sys_clk_in)
	begin
		rd_data_out <= mem_reg[rd_addr_in];
	end

endmodule

// >>> verilog/cix_exec.sv
// execute unit for the bit-test-skip, clear, call, watchdog, complement and decrement subset
`timescale 1ns/1ps
module cix_exec
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [11:0] instr_in,
	input wire logic instr_valid_in,
	output logic instr_ready_out,
	output logic [10:0] fetch_pc_out,
	input wire logic psa_wdt_in,
	input wire logic wdt_tick_in,
	input wire logic page_wr_in,
	input wire logic [1:0] page_data_in,
	output logic [7:0] w_out,
	output logic [7:0] status_out,
	output logic [7:0] watchdog_counter_out,
	output cix_pkg::cix_push_s push_out,
	output cix_pkg::cix_wdt_s wdt_ctl_out,
	output logic discard_out
);

	// ************************************************************************
	// state and storage
	// ************************************************************************
	typedef enum
	{
		ST_DECODE,
		ST_EXEC,
		ST_FLUSH
	} cix_state_e;

	cix_state_e state_reg; // sequencer state
	cix_state_e state_next;
	cix_pkg::cix_op_e op_reg; // latched operation
	cix_pkg::cix_op_e op_dec; // decode of incoming word
	logic [11:0] instr_reg; // latched instruction word
	logic [10:0] exec_pc_reg; // address of executing instruction
	logic [10:0] pc_reg; // next fetch address
	logic [7:0] w_reg; // working register
	logic [7:0] status_reg; // status flags and page
	logic [7:0] wdt_reg; // watchdog counter
	logic [7:0] file_rd; // operand from file memory
	logic [7:0] result; // computed result
	logic skip_now; // tested bit found set
	logic res_to_w; // write result to working register
	logic res_to_f; // write result to file register
	logic z_upd; // zero flag takes result
	logic accept; // handshake on instruction port
	cix_pkg::cix_push_s push_reg;
	cix_pkg::cix_wdt_s wdt_ctl_reg;
	logic discard_reg; // pulse when a fetched word is thrown away

	assign instr_ready_out = (state_reg != ST_EXEC);
	assign accept = instr_valid_in && instr_ready_out;
	assign fetch_pc_out = pc_reg;
	assign w_out = w_reg;
	assign status_out = status_reg;
	assign watchdog_counter_out = wdt_reg;
	assign push_out = push_reg;
	assign wdt_ctl_out = wdt_ctl_reg;
	assign discard_out = discard_reg;

	// ************************************************************************
	// file register memory
	// ************************************************************************
	// read address comes straight from the incoming word so data meet exec
	cix_file_mem cix_file_mem_i
	(
		.sys_clk_in(sys_clk_in),
		.rd_addr_in(instr_in[4:0]),
		.rd_data_out(file_rd),
		.wr_en_in(res_to_f),
		.wr_addr_in(instr_reg[4:0]),
		.wr_data_in(result)
	);

	// ************************************************************************
	// decode
	// ************************************************************************
	// unknown words fall to no-operation
	always_comb
	begin
		op_dec = cix_pkg::OP_NOP;
		if ((instr_in & cix_pkg::CLEAR_WORKING_REG_MASK) == cix_pkg::CLEAR_WORKING_REG_MATCH)
			op_dec = cix_pkg::OP_CLEAR_WORKING_REG;
		else if ((instr_in & cix_pkg::CLRWD_MASK) == cix_pkg::CLRWD_MATCH)
			op_dec = cix_pkg::OP_CLRWD;
		else if ((instr_in & cix_pkg::CLEAR_FILE_REG_MASK) == cix_pkg::CLEAR_FILE_REG_MATCH)
			op_dec = cix_pkg::OP_CLEAR_FILE_REG;
		else if ((instr_in & cix_pkg::COMPLEMENT_FILE_REG_MASK) == cix_pkg::COMPLEMENT_FILE_REG_MATCH)
			op_dec = cix_pkg::OP_COMPLEMENT_FILE_REG;
		else if ((instr_in & cix_pkg::DECREMENT_FILE_REG_MASK) == cix_pkg::DECREMENT_FILE_REG_MATCH)
			op_dec = cix_pkg::OP_DECREMENT_FILE_REG;
		else if ((instr_in & cix_pkg::BTSS_MASK) == cix_pkg::BTSS_MATCH)
			op_dec = cix_pkg::OP_BTSS;
		else if ((instr_in & cix_pkg::CALL_MASK) == cix_pkg::CALL_MATCH)
			op_dec = cix_pkg::OP_CALL;
	end

	// ************************************************************************
	// execute datapath
	// ************************************************************************
	always_comb
	begin
		result = 8'h00;
		res_to_w = 1'b0;
		res_to_f = 1'b0;
		z_upd = 1'b0;
		skip_now = 1'b0;
		if (state_reg == ST_EXEC)
		begin
			case (op_reg)
				cix_pkg::OP_BTSS:
				begin
					skip_now = file_rd[instr_reg[cix_pkg::BITSEL_HI:cix_pkg::BITSEL_LO]]; // RULE_01
				end
				cix_pkg::OP_CLEAR_WORKING_REG:
				begin
					result = 8'h00; // RULE_02
					res_to_w = 1'b1;
					z_upd = 1'b1;
				end
				cix_pkg::OP_CLEAR_FILE_REG:
				begin
					result = 8'h00; // RULE_10
					res_to_f = 1'b1;
					z_upd = 1'b1;
				end
				cix_pkg::OP_COMPLEMENT_FILE_REG:
				begin
					result = ~file_rd; // RULE_11
					res_to_w = ~instr_reg[cix_pkg::DEST_BIT]; // RULE_13
					res_to_f = instr_reg[cix_pkg::DEST_BIT]; // RULE_13
					z_upd = 1'b1;
				end
				cix_pkg::OP_DECREMENT_FILE_REG:
				begin
					result = file_rd - 8'h01; // RULE_12
					res_to_w = ~instr_reg[cix_pkg::DEST_BIT]; // RULE_13
					res_to_f = instr_reg[cix_pkg::DEST_BIT]; // RULE_13
					z_upd = 1'b1;
				end
				default:
				begin
					result = 8'h00; // call, watchdog and nop carry no data
				end
			endcase
		end
	end

	// ************************************************************************
	// sequencer
	// ************************************************************************
	// skip and call spend a second instruction slot flushing the fetched word
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_DECODE:
			begin
				if (accept)
					state_next = ST_EXEC;
			end
			ST_EXEC:
			begin
				if (skip_now || op_reg == cix_pkg::OP_CALL)
					state_next = ST_FLUSH; // RULE_01 RULE_06
				else
					state_next = ST_DECODE;
			end
			ST_FLUSH:
			begin
				if (accept)
					state_next = ST_DECODE;
			end
			default:
			begin
				state_next = ST_DECODE;
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			state_reg <= ST_DECODE;
		else
			state_reg <= state_next;
	end

	// latch incoming word on acceptance in decode
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
		begin
			instr_reg <= 12'h000;
			op_reg <= cix_pkg::OP_NOP;
			exec_pc_reg <= cix_pkg::PC_RESET;
		end
		else if (accept && state_reg == ST_DECODE)
		begin
			instr_reg <= instr_in;
			op_reg <= op_dec;
			exec_pc_reg <= pc_reg;
		end
	end

	// ************************************************************************
	// program counter and stack push
	// ************************************************************************
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			pc_reg <= cix_pkg::PC_RESET;
		else if (state_reg == ST_EXEC && op_reg == cix_pkg::OP_CALL)
			pc_reg <= {status_reg[cix_pkg::ST_PAGE_HI:cix_pkg::ST_PAGE_LO], 1'b0, instr_reg[7:0]}; // RULE_04 RULE_05
		else if (accept)
			pc_reg <= pc_reg + 11'h001; // skipped word still uses its address
	end

	// return address pushed as call executes
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			push_reg <= '0;
		else
		begin
			push_reg.valid <= (state_reg == ST_EXEC && op_reg == cix_pkg::OP_CALL); // RULE_03
			push_reg.addr <= exec_pc_reg + 11'h001; // RULE_03
		end
	end

	// discarded-word strobe
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			discard_reg <= 1'b0;
		else
			discard_reg <= (state_reg == ST_FLUSH) && accept; // RULE_01
	end

	// ************************************************************************
	// working register
	// ************************************************************************
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			w_reg <= 8'h00;
		else if (res_to_w)
			w_reg <= result; // RULE_13
	end

	// ************************************************************************
	// status register
	// ************************************************************************
	// skip and call never reach these branches, so flags hold
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			status_reg <= cix_pkg::STATUS_RESET;
		else
		begin
			if (page_wr_in)
				status_reg[cix_pkg::ST_PAGE_HI:cix_pkg::ST_PAGE_LO] <= page_data_in; // page select from software
			if (z_upd)
				status_reg[cix_pkg::ST_Z_BIT] <= (result == 8'h00); // RULE_14 RULE_15
			if (state_reg == ST_EXEC && op_reg == cix_pkg::OP_CLRWD)
			begin
				status_reg[cix_pkg::ST_TO_BIT] <= 1'b1; // RULE_09
				status_reg[cix_pkg::ST_PD_BIT] <= 1'b1; // RULE_09
			end
		end
	end

	// ************************************************************************
	// watchdog counter and prescaler control
	// ************************************************************************
	// clear beats a tick in the same cycle
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			wdt_reg <= cix_pkg::WDT_RESET;
		else if (state_reg == ST_EXEC && op_reg == cix_pkg::OP_CLRWD)
			wdt_reg <= 8'h00; // RULE_07
		else if (wdt_tick_in)
			wdt_reg <= wdt_reg + 8'h01;
	end

	// clear strobes to the timer side
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			wdt_ctl_reg <= '0;
		else
		begin
			wdt_ctl_reg.wdt_clear <= (state_reg == ST_EXEC && op_reg == cix_pkg::OP_CLRWD); // RULE_07
			wdt_ctl_reg.presc_clear <= (state_reg == ST_EXEC && op_reg == cix_pkg::OP_CLRWD) && psa_wdt_in; // RULE_08
		end
	end

endmodule

// >>> tb/cix_exec_chk.sv
// checker for the execute unit ports
`timescale 1ns/1ps
module cix_exec_chk
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [11:0] instr_in,
	input wire logic instr_valid_in,
	input wire logic instr_ready_out,
	input wire logic [10:0] fetch_pc_out,
	input wire logic psa_wdt_in,
	input wire logic [7:0] w_out,
	input wire logic [7:0] status_out,
	input wire logic [7:0] watchdog_counter_out,
	input wire cix_pkg::cix_push_s push_out,
	input wire cix_pkg::cix_wdt_s wdt_ctl_out,
	input wire logic discard_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// ************************************************************************
	// decode helpers
	// ************************************************************************
	logic acc; // word taken this edge
	logic wdc;
	logic call_w;
	logic zop; // complement or decrement into working
	logic [11:0] held_reg; // last taken word
	logic [10:0] addr_reg; // its fetch address
	assign acc = instr_valid_in && instr_ready_out;
	assign wdc = acc && (instr_in == cix_pkg::CLRWD_MATCH);
	assign call_w = acc && ((instr_in & cix_pkg::CALL_MASK) == cix_pkg::CALL_MATCH);
	assign zop = acc && !instr_in[5] && (((instr_in & cix_pkg::COMPLEMENT_FILE_REG_MASK) == cix_pkg::COMPLEMENT_FILE_REG_MATCH)
		|| ((instr_in & cix_pkg::DECREMENT_FILE_REG_MASK) == cix_pkg::DECREMENT_FILE_REG_MATCH));
	// capture at accept so results two edges on can be tied back
	always_ff @(posedge sys_clk_in)
	begin
		if (acc)
		begin
			held_reg <= instr_in;
			addr_reg <= fetch_pc_out;
		end
	end
	// ************************************************************************
	// assertions
	// ************************************************************************
	// a decode accept drops ready for the execute slot; a flush accept returns
	// straight to decode with the discard pulse, so the two must always agree
	ready_drop_a: assert property (acc |=> instr_ready_out == discard_out)
		else $error("ready wrong after accept");
	clear_working_reg_zero_a: assert property ((acc && instr_in == 12'h040 ##1 !discard_out) |=> w_out == 8'h00 && status_out[2])
		else $error("working clear wrong");
	wdt_clear_a: assert property ((wdc ##1 !discard_out) |=> watchdog_counter_out == 8'h00 && wdt_ctl_out.wdt_clear)
		else $error("counter not cleared");
	presc_clear_a: assert property ((wdc ##1 !discard_out) |=> wdt_ctl_out.presc_clear == $past(psa_wdt_in))
		else $error("prescaler clear wrong");
	wdt_flags_a: assert property ((wdc ##1 !discard_out) |=> status_out[4:3] == 2'b11 && $stable(status_out[2]))
		else $error("flags wrong after watchdog clear");
	call_target_a: assert property ((call_w ##1 !discard_out) |=> fetch_pc_out == {status_out[6:5], 1'b0, held_reg[7:0]})
		else $error("call target wrong");
	call_push_a: assert property ((call_w ##1 !discard_out) |=> push_out.valid && push_out.addr == addr_reg + 11'h001)
		else $error("return address wrong");
	call_flags_a: assert property ((call_w ##1 !discard_out) |=> $stable(status_out))
		else $error("call changed status");
	discard_keep_a: assert property ((acc ##1 discard_out) |=> $stable(w_out) && $stable(status_out))
		else $error("discarded word had effect");
	zero_flag_a: assert property ((zop ##1 !discard_out) |=> status_out[2] == (w_out == 8'h00))
		else $error("zero flag wrong");
endmodule
bind cix_exec cix_exec_chk cix_exec_chk_i(.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
	.instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out), .fetch_pc_out(fetch_pc_out),
	.psa_wdt_in(psa_wdt_in), .w_out(w_out), .status_out(status_out), .watchdog_counter_out(watchdog_counter_out),
	.push_out(push_out), .wdt_ctl_out(wdt_ctl_out), .discard_out(discard_out));

// >>> tb/cix_exec_tb.sv
// self-checking bench for the execute unit
`timescale 1ns/1ps
module cix_exec_tb;
	// ************************************************************************
	// signals
	// ************************************************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic valid = 1'b0;
	logic psa = 1'b1;
	logic tick = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] instr = 12'h000;
	logic [1:0] pdat = 2'b00;
	logic rdy, disc;
	logic [10:0] pc_o;
	logic [7:0] w_o, st_o, wd_o;
	cix_pkg::cix_push_s push_o;
	cix_pkg::cix_wdt_s wctl_o;
	int fail_count = 0;
	int num_checks = 0;
	int accepts = 0; // words taken since reset
	logic z = 1'b0; // expected zero flag
	logic [1:0] pg = 2'b00; // expected page
	always #4 clk = ~clk;
	cix_exec cix_exec_i(.sys_clk_in(clk), .rst_n_in(rst_n), .instr_in(instr), .instr_valid_in(valid),
		.instr_ready_out(rdy), .fetch_pc_out(pc_o), .psa_wdt_in(psa), .wdt_tick_in(tick), .page_wr_in(pwr),
		.page_data_in(pdat), .w_out(w_o), .status_out(st_o), .watchdog_counter_out(wd_o), .push_out(push_o),
		.wdt_ctl_out(wctl_o), .discard_out(disc));
	// ************************************************************************
	// helpers
	// ************************************************************************
	task automatic check(input logic [10:0] seen, input logic [10:0] exp, input string msg);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	function automatic logic [7:0] st_exp();
		return {1'b0, pg, 2'b11, z, 2'b00};
	endfunction
	// hold the word until ready is seen, release on the accept edge
	task automatic issue(input logic [11:0] word);
		int n;
		n = 0;
		@(posedge clk);
		instr <= word;
		valid <= 1'b1;
		@(negedge clk);
		while (rdy !== 1'b1 && n < 8)
		begin
			@(negedge clk);
			n++;
		end
		check(rdy, 1'b1, "ready");
		@(posedge clk);
		valid <= 1'b0;
		accepts++;
	endtask
	// results and pulses are settled one edge after the accept edge
	task automatic run(input logic [11:0] word);
		issue(word);
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		accepts = 0;
		z = 1'b0;
		pg = 2'b00;
		@(negedge clk);
		check(st_o, cix_pkg::STATUS_RESET, "status reset");
		check(w_o, 8'h00, "w reset");
		check(pc_o, cix_pkg::PC_RESET, "pc reset");
		check(wd_o, cix_pkg::WDT_RESET, "counter reset");
	endtask
	// ************************************************************************
	// scenarios
	// ************************************************************************
	task automatic t_wdt(input logic to_wdt);
		@(posedge clk);
		psa <= to_wdt;
		repeat (3)
		begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
		@(negedge clk);
		check(wd_o, 8'h03, "ticks");
		run(12'h004);
		check(wd_o, 8'h00, "counter");
		check(wctl_o.wdt_clear, 1'b1, "clear pulse");
		check(wctl_o.presc_clear, to_wdt, "prescaler");
		check(st_o, st_exp(), "flags");
	endtask
	// memory is not reset, so values are built up from a cleared cell
	task automatic t_file();
		run(12'h063);
		z = 1'b1;
		check(st_o, st_exp(), "clear file");
		run(12'h0e3);
		z = 1'b0;
		check(st_o, st_exp(), "dec to ff");
		run(12'h243);
		z = 1'b1;
		check(w_o, 8'h00, "comp ff");
		check(st_o, st_exp(), "comp zero");
		run(12'h0e3);
		run(12'h243);
		z = 1'b0;
		check(w_o, 8'h01, "comp fe");
		check(st_o, st_exp(), "comp nonzero");
		run(12'h0c3);
		check(w_o, 8'hfd, "dec to w");
		run(12'h243);
		check(w_o, 8'h01, "file kept");
		run(12'h040);
		z = 1'b1;
		check(w_o, 8'h00, "clear w");
		check(st_o, st_exp(), "clear w zero");
	endtask
	task automatic t_skip();
		run(12'h243);
		z = 1'b0;
		run(12'h723);
		check(st_o, st_exp(), "skip flags");
		issue(12'h040);
		@(negedge clk);
		check(disc, 1'b1, "discard");
		@(posedge clk);
		@(negedge clk);
		check(w_o, 8'h01, "skipped word");
		run(12'h703);
		run(12'h040);
		z = 1'b1;
		check(w_o, 8'h00, "no skip");
	endtask
	task automatic t_call(input logic [1:0] page, input logic [7:0] k, input logic [10:0] target);
		int n;
		@(posedge clk);
		pwr <= 1'b1;
		pdat <= page;
		@(posedge clk);
		pwr <= 1'b0;
		pg = page;
		n = accepts;
		run({4'h9, k});
		check(pc_o, target, "target");
		check(push_o.valid, 1'b1, "push");
		check(push_o.addr, 11'(n + 1), "return addr");
		check(st_o, st_exp(), "call flags");
		issue(12'h040);
		@(negedge clk);
		check(disc, 1'b1, "call discard");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		do_reset();
		t_wdt(1'b1);
		t_wdt(1'b0);
		t_file();
		t_skip();
		t_call(2'b10, 8'hab, 11'h4ab);
		do_reset();
		t_call(2'b01, 8'hff, 11'h2ff);
		close_out();
	end
	// hang guard, far beyond the hundred or so cycles needed
	initial
	begin
		#20000;
		fail_count++;
		close_out();
	end
endmodule
